// ---- bench/peer_chain_model.sv ----
// stand-in for the peer devices and board wiring around the token ring
// assumes token_from_dut is a registered one-cycle pulse on ref_clk
`timescale 1ns/1ns
module peer_chain_model (
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // control from the bench
   input wire logic loop_en,
   input wire logic kick,
   input wire logic [1:0] delay,
   // token ring
   input wire logic token_from_dut,
   output logic token_to_dut
);
   logic [3:0] pipe_ff;

   // ***************************
   // ring return path
   // ***************************
   // loop_en low models a tied-low token input in direct mode
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         pipe_ff <= 4'h0;
      end else begin
         pipe_ff <= {pipe_ff[2:0], loop_en & token_from_dut};
      end
   end

   // kick stands for the token of a preceding device in the chain
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         token_to_dut <= 1'b0;
      end else begin
         token_to_dut <= kick | pipe_ff[delay];
      end
   end
endmodule

// ---- bench/tb.sv ----
// self-checking bench for the expansion select block
// assumes the peer chain model closes the token ring
`timescale 1ns/1ns
module tb;
   logic ref_clk = 1'b0, sys_rst = 1'b1, master_reset_n = 1'b1;
   logic ft_pin = 1'b0, fs_pin = 1'b0, loop_en = 1'b0, kick = 1'b0;
   logic [2:0] id_pin = 3'h0;
   logic [1:0] delay = 2'h0;
   logic wsel_en = 1'b0, rsel_en = 1'b0;
   logic [7:0] waddr = 8'h00, raddr = 8'h00, awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic tok_in, tok_out, psync, oe_n, ft_mode, wsel, rsel;
   logic [7:0] bus;
   logic [7:0] words [4] = '{8'h11, 8'h22, 8'h33, 8'h44};
   logic [31:0] rd;
   logic [1:0] rsp;
   int failures = 0, checks = 0;

   always #50 ref_clk = ~ref_clk;

   queue_device_expansion_select u_dut (
      .ref_clk(ref_clk), .sys_rst(sys_rst),
      .master_reset_n(master_reset_n), .fall_through_select(ft_pin),
      .flag_scan_select(fs_pin), .chip_identity(id_pin),
      .write_select_en(wsel_en), .write_queue_address(waddr),
      .read_select_en(rsel_en), .read_queue_address(raddr),
      .flag_token_in(tok_in), .flag_token_out(tok_out), .poll_sync(psync),
      .almost_full_flag_bus(bus), .almost_full_flag_bus_oe_n(oe_n),
      .fall_through_mode(ft_mode), .write_selected(wsel),
      .read_selected(rsel),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready)
   );

   peer_chain_model u_peer (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .loop_en(loop_en),
      .kick(kick), .delay(delay), .token_from_dut(tok_out),
      .token_to_dut(tok_in)
   );

   // ***************************
   // shared tasks
   // ***************************
   task automatic report_and_stop();
      if (failures == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // ready is sampled at the falling edge; inputs only move at rising edges
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                            input logic [3:0] s, output logic [1:0] r);
      bit aw_done, w_done, a_rdy, w_rdy;
      int n;
      aw_done = 0;
      w_done = 0;
      n = 0;
      @(posedge ref_clk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wstrb <= s;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_done && w_done) && n < 50) begin
         @(negedge ref_clk);
         a_rdy = (awready === 1'b1);
         w_rdy = (wready === 1'b1);
         @(posedge ref_clk);
         if (a_rdy && !aw_done) begin
            awvalid <= 1'b0;
            aw_done = 1;
         end
         if (w_rdy && !w_done) begin
            wvalid <= 1'b0;
            wstrb <= 4'h0;
            w_done = 1;
         end
         n++;
      end
      r = 2'h1;
      for (int i = 0; i < 50; i++) begin
         @(negedge ref_clk);
         if (bvalid === 1'b1) begin
            r = bresp;
            @(posedge ref_clk);
            bready <= 1'b0;
            break;
         end
      end
      if (n >= 50 || r === 2'h1) begin
         failures++;
      end
   endtask

   task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                           output logic [1:0] r);
      bit got;
      got = 0;
      d = 32'hdead_beef;
      r = 2'h1;
      @(posedge ref_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int i = 0; i < 50 && !got; i++) begin
         @(negedge ref_clk);
         if (arready === 1'b1 && arvalid) begin
            @(posedge ref_clk);
            arvalid <= 1'b0;
         end else if (rvalid === 1'b1) begin
            d = rdata;
            r = rresp;
            got = 1;
            @(posedge ref_clk);
            rready <= 1'b0;
         end
      end
      if (!got) begin
         failures++;
      end
   endtask

   task automatic mreset(input logic ft, input logic fs, input logic [2:0] id);
      @(posedge ref_clk);
      master_reset_n <= 1'b0;
      ft_pin <= ft;
      fs_pin <= fs;
      id_pin <= id;
      repeat (5) @(posedge ref_clk);
      master_reset_n <= 1'b1;
   endtask

   // one full visit of this device on the flag bus
   task automatic walk();
      for (int n = 0; n < 30 && oe_n !== 1'b0; n++) begin
         @(negedge ref_clk);
      end
      check(oe_n, 1'b0);
      check(psync, 1'b1);
      check(bus, words[0]);
      check(tok_out, 1'b0);
      for (int i = 1; i < 4; i++) begin
         @(negedge ref_clk);
         check(bus, words[i]);
         check(psync, 1'b0);
         check(tok_out, 32'(i == 3));
      end
      @(negedge ref_clk);
      check(oe_n, 1'b1);
   endtask

   task automatic select(input bit wr, input logic [7:0] a, input logic exp);
      @(posedge ref_clk);
      if (wr) begin
         wsel_en <= 1'b1;
         waddr <= a;
      end else begin
         rsel_en <= 1'b1;
         raddr <= a;
      end
      @(posedge ref_clk);
      wsel_en <= 1'b0;
      rsel_en <= 1'b0;
      repeat (4) @(negedge ref_clk);
      check(wr ? wsel : rsel, exp);
   endtask

   // ***************************
   // watchdog and main sequence
   // ***************************
   initial begin
      #2000000;
      failures++;
      report_and_stop();
   end

   initial begin
      repeat (6) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(negedge ref_clk);
      check(oe_n, 1'b1);
      check(awready, 1'b1);
      for (int i = 0; i < 4; i++) begin
         axi_write(8'(4 * i), {24'h0, words[i]}, 4'hf, rsp);
         check(rsp, expansion_pkg::RESP_OKAY);
      end
      // low strobe on the status byte leaves the word alone
      axi_write(expansion_pkg::STATUS_WORD0_OFS, 32'hff, 4'he, rsp);
      axi_read(expansion_pkg::STATUS_WORD0_OFS, rd, rsp);
      check(rd, 32'(words[0]));
      axi_read(8'h14, rd, rsp);
      check({rd[7:0], 6'h0, rsp}, {8'h0, 6'h0, expansion_pkg::RESP_SLVERR});
      axi_read(8'h02, rd, rsp);
      check(rsp, expansion_pkg::RESP_SLVERR);
      axi_write(expansion_pkg::MODE_STATUS_OFS, 32'h0, 4'hf, rsp);
      check(rsp, expansion_pkg::RESP_SLVERR);
      // single device, polled, token looped back to itself
      loop_en <= 1'b1;
      mreset(1'b0, 1'b1, 3'h0);
      walk();
      walk();
      @(negedge ref_clk);
      check(ft_mode, 1'b1);
      axi_read(expansion_pkg::MODE_STATUS_OFS, rd, rsp);
      check(rd[4:0], 5'h03);
      // chain member with identity 7 waits for the preceding token
      loop_en <= 1'b0;
      delay <= 2'h3;
      mreset(1'b1, 1'b1, 3'h7);
      repeat (12) @(negedge ref_clk);
      check(oe_n, 1'b1);
      check(ft_mode, 1'b0);
      @(posedge ref_clk);
      kick <= 1'b1;
      @(posedge ref_clk);
      kick <= 1'b0;
      walk();
      // direct mode, identity 5: token ignored, bus stays released
      mreset(1'b1, 1'b0, 3'h5);
      repeat (4) @(posedge ref_clk);
      kick <= 1'b1;
      @(posedge ref_clk);
      kick <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         @(negedge ref_clk);
         check({oe_n, bus}, 9'h100);
      end
      select(1'b1, {3'h4, 5'h0a}, 1'b0);
      select(1'b1, {3'h5, 5'h0a}, 1'b1);
      select(1'b0, {3'h2, 5'h13}, 1'b0);
      select(1'b0, {3'h5, 5'h13}, 1'b1);
      axi_read(expansion_pkg::MODE_STATUS_OFS, rd, rsp);
      check(rd & 32'h03fffc7f, (32'h5 << expansion_pkg::ID_LSB)
            | (32'h1 << expansion_pkg::WSEL_BIT)
            | (32'h1 << expansion_pkg::RSEL_BIT)
            | (32'h0a << expansion_pkg::WQ_LSB)
            | (32'h13 << expansion_pkg::RQ_LSB));
      // identity-zero master brought up last, polled loopback again
      loop_en <= 1'b1;
      mreset(1'b0, 1'b1, 3'h0);
      walk();
      select(1'b1, {3'h0, 5'h07}, 1'b1);
      report_and_stop();
   end
endmodule

// ---- design/expansion_pkg.sv ----
// constants shared by the expansion select logic and its poll sequencer
// assumes a single ref_clk domain and an AXI4-Lite register master
package expansion_pkg;
   // ***************************
   // widths
   // ***************************
   localparam int ADDR_W = 8;
   localparam int ID_W = 3;
   localparam int DEV_BITS_DEFAULT = 3;
   localparam int WORD_W = 8;
   localparam int WORDS = 4;
   localparam logic [1:0] LAST_WORD = 2'h3;
   localparam logic [1:0] FIRST_WORD = 2'h0;

   // ***************************
   // register map (byte addresses)
   // ***************************
   localparam logic [7:0] STATUS_WORD0_OFS = 8'h00;
   localparam logic [7:0] STATUS_WORD3_OFS = 8'h0c;
   localparam logic [7:0] MODE_STATUS_OFS = 8'h10;
   localparam logic [7:0] STATUS_WORD_RST = 8'h00;

   // ***************************
   // mode status fields
   // ***************************
   localparam int FT_BIT = 0;
   localparam int POLLED_BIT = 1;
   localparam int ID_LSB = 2;
   localparam int WSEL_BIT = 5;
   localparam int RSEL_BIT = 6;
   localparam int DRIVE_BIT = 7;
   localparam int WORD_LSB = 8;
   localparam int WQ_LSB = 10;
   localparam int RQ_LSB = 18;

   // ***************************
   // bus responses
   // ***************************
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic {POLL_IDLE, POLL_DRIVE} poll_state_t;
endpackage

// ---- design/poll_sequencer.sv ----
// walks the four status words of one device across the flag bus
// assumes token_in is already synchronised to ref_clk
`timescale 1ns/1ns
module poll_sequencer (
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // control
   input wire logic polled,
   input wire logic start,
   input wire logic token_in,
   // poll state
   output logic drive,
   output logic [1:0] word,
   output logic poll_sync,
   output logic token_out
);
   expansion_pkg::poll_state_t state_ff;
   logic [1:0] word_ff;

   // ***************************
   // sequencing
   // ***************************
   // a token arriving while words are still being driven is dropped;
   // a healthy ring never does that
   always_ff @(posedge ref_clk) begin
      if (sys_rst || !polled) begin
         state_ff <= expansion_pkg::POLL_IDLE;
         word_ff <= expansion_pkg::FIRST_WORD;
      end else begin
         case (state_ff)
            expansion_pkg::POLL_IDLE: begin
               if (token_in || start) begin
                  state_ff <= expansion_pkg::POLL_DRIVE;
                  word_ff <= expansion_pkg::FIRST_WORD;
               end
            end
            expansion_pkg::POLL_DRIVE: begin
               if (word_ff == expansion_pkg::LAST_WORD) begin
                  state_ff <= expansion_pkg::POLL_IDLE;
                  word_ff <= expansion_pkg::FIRST_WORD;
               end else begin
                  word_ff <= word_ff + 2'h1;
               end
            end
            default: state_ff <= expansion_pkg::POLL_IDLE;
         endcase
      end
   end

   assign drive = (state_ff == expansion_pkg::POLL_DRIVE);
   assign word = word_ff;
   assign poll_sync = drive && (word_ff == expansion_pkg::FIRST_WORD);
   assign token_out = drive && (word_ff == expansion_pkg::LAST_WORD);

   // ***************************
   // checks
   // ***************************
   tok_start_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (!drive && token_in && polled) |=> (drive && poll_sync))
      else $error("token did not start first word");
   word_step_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (drive && word != 2'h3 && polled) |=> (drive && word == $past(word) + 2'h1))
      else $error("status word did not advance");
   tok_out_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (poll_sync && polled) |-> ##3 (token_out && !poll_sync))
      else $error("token out not on fourth word");
   sync_once_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      poll_sync |=> !poll_sync [*3])
      else $error("poll sync high on a later word");
   wrap_word_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (token_out && !token_in && !start) |=> !drive)
      else $error("drive kept after fourth word");
   ring_pass_c: cover property (@(posedge ref_clk) disable iff (sys_rst)
      token_in ##1 poll_sync ##3 token_out);
endmodule

// ---- design/queue_device_expansion_select.sv ----
// expansion select: reset straps, chip identity match, poll token ring,
// AXI4-Lite register slave holding the four status words
// assumes every pin input is asynchronous to ref_clk
//
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ns
// Function
// - low fall-through select at master reset picks fall-through, high picks standard
// - in polled chain, accept flag bus token from previous device on token input
// - polled: pulse token output while fourth status word is on bus
// - edge after token receipt: drive first status word onto flag bus (here the third edge after the token pin, behind the two-stage synchroniser)
// - queue address buses 8 bits; upper bits pick device, lower pick queue
// - compare device bits with chip identity; respond only on match
// - identity latched at master reset; board keeps it stable
// - identities any order, eight devices, zero through seven
// - polled: one status word per edge, back to first after fourth
// - poll sync high while first word driven, low otherwise
// - flag scan select at master reset: high polled, low direct
module queue_device_expansion_select #(
   parameter int DEV_BITS = expansion_pkg::DEV_BITS_DEFAULT
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // straps and master reset pins
   input wire logic master_reset_n,
   input wire logic fall_through_select,
   input wire logic flag_scan_select,
   input wire logic [expansion_pkg::ID_W-1:0] chip_identity,
   // queue selection pins
   input wire logic write_select_en,
   input wire logic [expansion_pkg::ADDR_W-1:0] write_queue_address,
   input wire logic read_select_en,
   input wire logic [expansion_pkg::ADDR_W-1:0] read_queue_address,
   // token ring and flag bus
   input wire logic flag_token_in,
   output logic flag_token_out,
   output logic poll_sync,
   output logic [expansion_pkg::WORD_W-1:0] almost_full_flag_bus,
   output logic almost_full_flag_bus_oe_n,
   // selection results
   output logic fall_through_mode,
   output logic write_selected,
   output logic read_selected,
   // axi4-lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   localparam int PW = 7 + 2 * expansion_pkg::ADDR_W + expansion_pkg::ID_W;
   // ***************************
   // functions
   // ***************************
   function automatic logic dev_match(input logic [7:0] a,
                                      input logic [2:0] id);
      return (a >> (8 - DEV_BITS)) == (8'(id) & (8'hff >> (8 - DEV_BITS)));
   endfunction
   function automatic logic [7:0] queue_of(input logic [7:0] a);
      return a & (8'hff >> DEV_BITS);
   endfunction
   // ***************************
   // pin synchronisers
   // ***************************
   logic [PW-1:0] pin_meta_ff;
   logic [PW-1:0] pin_sync_ff;
   logic mrs_s, ft_s, fm_s, wen_s, ren_s, tok_s;
   logic [2:0] id_s;
   logic [7:0] wa_s, ra_s;
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         pin_meta_ff <= '0;
         pin_sync_ff <= '0;
      end else begin
         pin_meta_ff <= {master_reset_n, fall_through_select,
                         flag_scan_select, write_select_en, read_select_en,
                         flag_token_in, 1'b0, chip_identity,
                         write_queue_address, read_queue_address};
         pin_sync_ff <= pin_meta_ff;
      end
   end
   assign {mrs_s, ft_s, fm_s, wen_s, ren_s, tok_s} = pin_sync_ff[PW-1 -: 6];
   assign id_s = pin_sync_ff[2*8 +: 3];
   assign wa_s = pin_sync_ff[8 +: 8];
   assign ra_s = pin_sync_ff[0 +: 8];
   // ***************************
   // master reset straps
   // ***************************
   logic ft_ff, polled_ff, mrs_prev_ff;
   logic [2:0] id_ff;
   // straps follow the pins for the whole master reset, frozen after it
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         ft_ff <= 1'b0;
         polled_ff <= 1'b0;
         id_ff <= 3'h0;
         mrs_prev_ff <= 1'b0;
      end else begin
         mrs_prev_ff <= mrs_s;
         if (!mrs_s) begin
            ft_ff <= !ft_s;
            polled_ff <= fm_s;
            id_ff <= id_s;
         end
      end
   end
   assign fall_through_mode = ft_ff;
   // ***************************
   // queue selection
   // ***************************
   logic wsel_ff, rsel_ff;
   logic [7:0] wq_ff, rq_ff;
   always_ff @(posedge ref_clk) begin
      if (sys_rst || !mrs_s) begin
         wsel_ff <= 1'b0;
         wq_ff <= 8'h00;
      end else if (wen_s) begin
         wsel_ff <= dev_match(wa_s, id_ff);
         wq_ff <= queue_of(wa_s);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst || !mrs_s) begin
         rsel_ff <= 1'b0;
         rq_ff <= 8'h00;
      end else if (ren_s) begin
         rsel_ff <= dev_match(ra_s, id_ff);
         rq_ff <= queue_of(ra_s);
      end
   end
   assign write_selected = wsel_ff;
   assign read_selected = rsel_ff;
   // ***************************
   // poll ring
   // ***************************
   logic drive, start;
   logic [1:0] word;
   logic [7:0] status_ff [expansion_pkg::WORDS];
   // identity zero opens the ring once master reset lifts
   assign start = mrs_s && !mrs_prev_ff && (id_ff == 3'h0);
   poll_sequencer u_seq (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst || !mrs_s),
      .polled(polled_ff),
      .start(start),
      .token_in(tok_s),
      .drive(drive),
      .word(word),
      .poll_sync(poll_sync),
      .token_out(flag_token_out)
   );
   // direct-mode word selection is outside this block, so the bus floats
   assign almost_full_flag_bus = drive ? status_ff[word] : 8'h00;
   assign almost_full_flag_bus_oe_n = !drive;
   // ***************************
   // axi4-lite slave
   // ***************************
   logic aw_held_ff, w_held_ff, bvalid_ff, rvalid_ff, wlane0_ff;
   logic [7:0] aw_ff;
   logic [31:0] w_ff, rdata_ff;
   logic [1:0] bresp_ff, rresp_ff;
   logic aw_take, w_take, ar_take, wr_go;
   assign s_axi_awready = !aw_held_ff && !bvalid_ff;
   assign s_axi_wready = !w_held_ff && !bvalid_ff;
   assign s_axi_arready = !rvalid_ff;
   assign aw_take = s_axi_awvalid && s_axi_awready;
   assign w_take = s_axi_wvalid && s_axi_wready;
   assign ar_take = s_axi_arvalid && s_axi_arready;
   assign wr_go = aw_held_ff && w_held_ff;
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         aw_held_ff <= 1'b0;
         w_held_ff <= 1'b0;
         aw_ff <= 8'h00;
         w_ff <= 32'h0;
         wlane0_ff <= 1'b0;
      end else if (wr_go) begin
         aw_held_ff <= 1'b0;
         w_held_ff <= 1'b0;
      end else begin
         if (aw_take) begin
            aw_held_ff <= 1'b1;
            aw_ff <= s_axi_awaddr;
         end
         if (w_take) begin
            w_held_ff <= 1'b1;
            w_ff <= s_axi_wdata;
            wlane0_ff <= s_axi_wstrb[0];
         end
      end
   end
   // low byte lane only; strobe latched with w, as w may move once taken
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         for (int i = 0; i < expansion_pkg::WORDS; i++) begin
            status_ff[i] <= expansion_pkg::STATUS_WORD_RST;
         end
      end else if (wr_go && aw_ff[1:0] == 2'h0 && wlane0_ff &&
                   aw_ff <= expansion_pkg::STATUS_WORD3_OFS) begin
         status_ff[aw_ff[3:2]] <= w_ff[7:0];
      end
   end
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         bvalid_ff <= 1'b0;
         bresp_ff <= expansion_pkg::RESP_OKAY;
      end else if (wr_go) begin
         bvalid_ff <= 1'b1;
         bresp_ff <= (aw_ff[1:0] == 2'h0 &&
                      aw_ff <= expansion_pkg::STATUS_WORD3_OFS) ?
                     expansion_pkg::RESP_OKAY : expansion_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_ff <= 1'b0;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0;
         rresp_ff <= expansion_pkg::RESP_OKAY;
      end else if (ar_take) begin
         rvalid_ff <= 1'b1;
         rresp_ff <= expansion_pkg::RESP_OKAY;
         rdata_ff <= 32'h0;
         if (s_axi_araddr[1:0] == 2'h0 &&
             s_axi_araddr <= expansion_pkg::STATUS_WORD3_OFS) begin
            rdata_ff <= {24'h0, status_ff[s_axi_araddr[3:2]]};
         end else if (s_axi_araddr == expansion_pkg::MODE_STATUS_OFS) begin
            rdata_ff[expansion_pkg::FT_BIT] <= ft_ff;
            rdata_ff[expansion_pkg::POLLED_BIT] <= polled_ff;
            rdata_ff[expansion_pkg::ID_LSB +: 3] <= id_ff;
            rdata_ff[expansion_pkg::WSEL_BIT] <= wsel_ff;
            rdata_ff[expansion_pkg::RSEL_BIT] <= rsel_ff;
            rdata_ff[expansion_pkg::DRIVE_BIT] <= drive;
            rdata_ff[expansion_pkg::WORD_LSB +: 2] <= word;
            rdata_ff[expansion_pkg::WQ_LSB +: 8] <= wq_ff;
            rdata_ff[expansion_pkg::RQ_LSB +: 8] <= rq_ff;
         end else begin
            rresp_ff <= expansion_pkg::RESP_SLVERR;
         end
      end else if (s_axi_rready) begin
         rvalid_ff <= 1'b0;
      end
   end
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;
   // ***************************
   // checks
   // ***************************
   ft_latch_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !mrs_s |=> (fall_through_mode == !$past(ft_s)))
      else $error("fall-through strap not taken");
   scan_latch_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !mrs_s |=> (polled_ff == $past(fm_s)))
      else $error("flag scan strap not taken");
   id_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (mrs_s && $past(mrs_s)) |-> $stable(id_ff))
      else $error("identity moved outside master reset");
   wr_match_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (mrs_s && wen_s && DEV_BITS == 3) |=> (wq_ff == ($past(wa_s) & 8'h1f) &&
         write_selected == (($past(wa_s) >> 5) == 8'(id_ff))))
      else $error("write select does not follow identity");
   rd_match_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (mrs_s && ren_s && ra_s[7:5] != id_ff && DEV_BITS == 3) |=> !read_selected)
      else $error("read selected on foreign identity");
   bus_word_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      poll_sync |-> (!almost_full_flag_bus_oe_n &&
         almost_full_flag_bus == status_ff[0]))
      else $error("first status word not on bus");
   wsel_c: cover property (@(posedge ref_clk) disable iff (sys_rst)
      wen_s ##1 write_selected);
   ring_c: cover property (@(posedge ref_clk) disable iff (sys_rst)
      flag_token_out ##[1:8] poll_sync);
   axi_c: cover property (@(posedge ref_clk) disable iff (sys_rst)
      s_axi_bvalid ##[1:20] s_axi_rvalid);
endmodule
